// ==== design/acrss_pkg.sv ====
// ****************************************************************
// converter clock, reference and sweep-select constants
// ****************************************************************
package acrss_pkg;

    // ************************************************************
    // bus geometry
    // ************************************************************
    localparam int unsigned ADR_W  = 14;
    localparam int unsigned DAT_W  = 32;
    localparam int unsigned SEL_W  = 4;
    localparam int unsigned IDX_W  = 12;
    localparam int unsigned IDX_LO = 2;
    localparam int unsigned REG_W  = 8;

    // register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_SWEEP_CTRL = 12'hf71;
    localparam logic [IDX_W-1:0] IDX_CLK_REF    = 12'hf72;
    localparam logic [IDX_W-1:0] IDX_UPPER_MASK = 12'hf73;
    localparam logic [IDX_W-1:0] IDX_LOWER_SEL  = 12'hf74;

    // ************************************************************
    // field layout
    // ************************************************************
    localparam int unsigned DIV_W        = 4;
    localparam int unsigned REF_W        = 2;
    localparam int unsigned CR_REF_LO    = 6;
    localparam int unsigned CR_DIV_LO    = 0;
    localparam int unsigned SC_SWEEP_BIT = 5;
    localparam int unsigned SC_DIFF_BIT  = 3;
    localparam int unsigned UM_MASK_W    = 7;
    localparam int unsigned CHAN_W       = 5;
    localparam int unsigned SET_W        = 15;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [REG_W-1:0]     RST_SWEEP_CTRL = 8'h00;
    localparam logic [REG_W-1:0]     RST_LOWER_SEL  = 8'h00;
    localparam logic [UM_MASK_W-1:0] RST_UPPER_MASK = 7'h00;
    localparam logic [DIV_W-1:0]     RST_DIV        = 4'h0;
    localparam logic [DAT_W-1:0]     RST_DAT        = 32'h0000_0000;
    localparam logic [1:0]           RSV_ZERO2      = 2'h0;
    localparam logic                 RSV_ZERO1      = 1'h0;

    // positive reference codes
    typedef enum logic [REF_W-1:0] {
        REF_SUPPLY = 2'h0,
        REF_EXT    = 2'h1,
        REF_RSVD   = 2'h2,
        REF_BIAS   = 2'h3
    } acrss_ref_t;

    // bus slave states, one-hot
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } acrss_bus_t;

endpackage

// ==== design/acrss_clkdiv.sv ====
`timescale 1ns/1ns
// ****************************************************************
// converter clock divider: one-cycle enable every (div + 1) clocks
// ****************************************************************
module acrss_clkdiv
    import acrss_pkg::*;
(
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // divide code
    input  wire logic [DIV_W-1:0] div_i,
    // converter clock enable
    output logic                  tick_o
);
    import acrss_pkg::*;

    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic [DIV_W-1:0] lim;
        logic             tick;
    } acrss_div_t;

    acrss_div_t st_r;
    acrss_div_t st_nxt;

    // new divide code only latched at terminal count, so no short period
    always_comb begin
        st_nxt = st_r;
        st_nxt.tick = (st_r.cnt == st_r.lim);
        if (st_r.cnt == st_r.lim) begin
            st_nxt.cnt = RST_DIV;
            st_nxt.lim = div_i;
        end else begin
            st_nxt.cnt = st_r.cnt + 4'h1;
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '{cnt: RST_DIV, lim: RST_DIV, tick: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick_o = st_r.tick;

endmodule // acrss_clkdiv

// ==== design/acrss_scanmask.sv ====
`timescale 1ns/1ns
// ****************************************************************
// swept channel set from lower and upper select registers
// ****************************************************************
module acrss_scanmask
    import acrss_pkg::*;
(
    // clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    // mode
    input  wire logic                 sweep_en_i,
    input  wire logic                 diff_i,
    // select registers
    input  wire logic [REG_W-1:0]     lower_i,
    input  wire logic [UM_MASK_W-1:0] upper_i,
    // set: [7:0] inputs 0-7, [12:8] inputs 8-12, [13] amp A0, [14] amp A1
    output logic      [SET_W-1:0]     set_o
);
    import acrss_pkg::*;

    typedef struct packed {
        logic [SET_W-1:0] set;
    } acrss_scan_t;

    acrss_scan_t st_r;
    acrss_scan_t st_nxt;

    // upper bits join only in single-ended sweeping; reserved otherwise
    always_comb begin
        st_nxt = st_r;
        if (!sweep_en_i) begin
            st_nxt.set = '0;
        end else if (diff_i) begin
            st_nxt.set = {{UM_MASK_W{1'b0}}, lower_i};
        end else begin
            st_nxt.set = {upper_i, lower_i};
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '{set: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign set_o = st_r.set;

endmodule // acrss_scanmask

// ==== design/acrss_top.sv ====
// Design decision made here: register access over Wishbone.
`timescale 1ns/1ns
// Behaviour
// - converter clock enable fires every divide code plus one system clocks
// - reference field picks supply, external pin, or buffered bias; code 10 reserved
// - clock/reference bits five and four read zero; software writes them zero
// - upper mask joins lower select in channel choice only while sweeping
// - single-ended sweep: upper bits add inputs 8-12, amp A0, amp A1
// - upper mask bits reserved when sweep off or differential sweep
// - sweeping on: upper mask read returns channel of held result
// - upper mask bit seven reads zero; software writes it zero
// - sweep-enable bit five of first control register switches sweeping
// - input-mode bit three selects single-ended (0) or differential (1)
module acrss_top
    import acrss_pkg::*;
(
    // clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,

    // wishbone classic slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [ADR_W-1:0]     wb_adr_i,
    input  wire logic [SEL_W-1:0]     wb_sel_i,
    input  wire logic [DAT_W-1:0]     wb_dat_i,
    output logic      [DAT_W-1:0]     wb_dat_o,
    output logic                      wb_ack_o,

    // from the conversion sequencer
    input  wire logic [CHAN_W-1:0]    result_channel_i,

    // converter clock
    output logic                      adc_clk_en_o,

    // positive reference control
    output logic      [REF_W-1:0]     positive_reference_select_o,
    output logic                      ref_use_supply_o,
    output logic                      ref_use_ext_pin_o,
    output logic                      ref_drive_bias_o,

    // sweep control
    output logic                      sweep_en_o,
    output logic                      differential_input_select_o,
    output logic      [SET_W-1:0]     sweep_set_o
);
    import acrss_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        acrss_bus_t           bus;
        logic [DAT_W-1:0]     dat;
        logic [REG_W-1:0]     sweep_ctrl;
        acrss_ref_t           positive_reference_select;
        logic [DIV_W-1:0]     div;
        logic [UM_MASK_W-1:0] upper;
        logic [REG_W-1:0]     lower;
        logic                 ref_supply;
        logic                 ref_ext;
        logic                 ref_bias;
    } acrss_state_t;

    acrss_state_t st_r;
    acrss_state_t st_nxt;

    logic [IDX_W-1:0] req_idx;
    logic             req_valid;
    logic             wr_lane0;

    // ************************************************************
    // helpers
    // ************************************************************

    // register hit: compare the word index of the bus address
    function automatic logic reg_hit(input logic [IDX_W-1:0] idx,
                                     input logic [IDX_W-1:0] want);
        reg_hit = (idx == want);
    endfunction

    // read value of one register, low byte of the bus word
    function automatic logic [REG_W-1:0] rd_byte(
        input logic [IDX_W-1:0]     idx,
        input acrss_state_t         s,
        input logic [CHAN_W-1:0]    chan
    );
        logic sweeping;
        sweeping = s.sweep_ctrl[SC_SWEEP_BIT];
        rd_byte  = '0;
        if (reg_hit(idx, IDX_SWEEP_CTRL)) begin
            rd_byte = s.sweep_ctrl;
        end else if (reg_hit(idx, IDX_CLK_REF)) begin
            rd_byte = {s.positive_reference_select, RSV_ZERO2, s.div};
        end else if (reg_hit(idx, IDX_UPPER_MASK)) begin
            if (sweeping) begin
                // held result's channel, not the mask
                rd_byte = {RSV_ZERO1, 2'h0, chan};
            end else begin
                rd_byte = {RSV_ZERO1, s.upper};
            end
        end else if (reg_hit(idx, IDX_LOWER_SEL)) begin
            rd_byte = s.lower;
        end else begin
            rd_byte = '0;
        end
    endfunction

    // ************************************************************
    // request decode
    // ************************************************************

    // word index; low two address bits ignored
    assign req_idx   = wb_adr_i[ADR_W-1:IDX_LO];
    assign req_valid = wb_cyc_i && wb_stb_i;
    // registers are one byte wide, so only lane 0 carries write data
    assign wr_lane0  = wb_we_i && wb_sel_i[0];

    // ************************************************************
    // next state
    // ************************************************************

    // bus slave: take request in idle, ack one cycle later, then drop.
    // the write lands on the edge where the master sees ack, so a
    // master that aborts before ack leaves the registers untouched.
    always_comb begin
        st_nxt = st_r;
        case (st_r.bus)
            BUS_IDLE: begin
                if (req_valid) begin
                    st_nxt.bus = BUS_ACK;
                    st_nxt.dat = {{(DAT_W-REG_W){1'b0}},
                                  rd_byte(req_idx, st_r, result_channel_i)};
                end
            end
            BUS_ACK: begin
                st_nxt.bus = BUS_IDLE;
                st_nxt.dat = RST_DAT;
                if (req_valid && wr_lane0) begin
                    if (reg_hit(req_idx, IDX_SWEEP_CTRL)) begin
                        // sweep enable and input mode live here
                        st_nxt.sweep_ctrl = wb_dat_i[REG_W-1:0];
                    end else if (reg_hit(req_idx, IDX_CLK_REF)) begin
                        // bits five and four are dropped: read-only zero
                        st_nxt.positive_reference_select =
                            acrss_ref_t'(wb_dat_i[CR_REF_LO +: REF_W]);
                        st_nxt.div = wb_dat_i[CR_DIV_LO +: DIV_W];
                    end else if (reg_hit(req_idx, IDX_UPPER_MASK)) begin
                        // bit seven is dropped: read-only zero
                        st_nxt.upper = wb_dat_i[UM_MASK_W-1:0];
                    end else if (reg_hit(req_idx, IDX_LOWER_SEL)) begin
                        st_nxt.lower = wb_dat_i[REG_W-1:0];
                    end else begin
                        // unmapped: acked, nothing stored
                        st_nxt.lower = st_r.lower;
                    end
                end
            end
            default: begin
                st_nxt.bus = BUS_IDLE;
            end
        endcase

        // reference decode; reserved code leaves every source off
        st_nxt.ref_supply = (st_nxt.positive_reference_select == REF_SUPPLY);
        st_nxt.ref_ext    = (st_nxt.positive_reference_select == REF_EXT);
        st_nxt.ref_bias   = (st_nxt.positive_reference_select == REF_BIAS);
    end

    // ************************************************************
    // state register
    // ************************************************************

    // synchronous reset: all registers to zero, bus to idle (one-hot 01), supply reference on
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r.bus        <= BUS_IDLE;
            st_r.dat        <= RST_DAT;
            st_r.sweep_ctrl <= RST_SWEEP_CTRL;
            st_r.positive_reference_select     <= REF_SUPPLY;
            st_r.div        <= RST_DIV;
            st_r.upper      <= RST_UPPER_MASK;
            st_r.lower      <= RST_LOWER_SEL;
            st_r.ref_supply <= 1'b1;
            st_r.ref_ext    <= 1'b0;
            st_r.ref_bias   <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ************************************************************
    // converter clock divider
    // ************************************************************

    // the divider latches the code itself at terminal count
    acrss_clkdiv u_clkdiv (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .div_i  (st_r.div),
        .tick_o (adc_clk_en_o)
    );

    // ************************************************************
    // swept channel set
    // ************************************************************

    // set lags a register write by one cycle
    acrss_scanmask u_scanmask (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .sweep_en_i (st_r.sweep_ctrl[SC_SWEEP_BIT]),
        .diff_i     (st_r.sweep_ctrl[SC_DIFF_BIT]),
        .lower_i    (st_r.lower),
        .upper_i    (st_r.upper),
        .set_o      (sweep_set_o)
    );

    // ************************************************************
    // outputs, all straight from flip-flops
    // ************************************************************
    assign wb_ack_o                    = st_r.bus[1];
    assign wb_dat_o                    = st_r.dat;
    assign positive_reference_select_o = st_r.positive_reference_select;
    assign ref_use_supply_o            = st_r.ref_supply;
    assign ref_use_ext_pin_o           = st_r.ref_ext;
    assign ref_drive_bias_o            = st_r.ref_bias;
    assign sweep_en_o                  = st_r.sweep_ctrl[SC_SWEEP_BIT];
    assign differential_input_select_o = st_r.sweep_ctrl[SC_DIFF_BIT];

endmodule // acrss_top

// ==== bench/acrss_assertions.sv ====
`timescale 1ns/1ns
// *******************************
// port-level checker
// *******************************
module acrss_checker
    import acrss_pkg::*;
(
    // clock and reset
    input wire logic              clk_i,
    input wire logic              rst_i,
    // bus
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic              wb_we_i,
    input wire logic [ADR_W-1:0]  wb_adr_i,
    input wire logic [DAT_W-1:0]  wb_dat_o,
    input wire logic              wb_ack_o,
    // converter side
    input wire logic [CHAN_W-1:0] result_channel_i,
    input wire logic              adc_clk_en_o,
    input wire logic [REF_W-1:0]  positive_reference_select_o,
    input wire logic              ref_use_supply_o,
    input wire logic              ref_use_ext_pin_o,
    input wire logic              ref_drive_bias_o,
    input wire logic              sweep_en_o,
    input wire logic              differential_input_select_o,
    input wire logic [SET_W-1:0]  sweep_set_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [4:0] gap_r;
    // idle cycles since the last converter clock pulse
    always_ff @(posedge clk_i) begin
        gap_r <= (rst_i || adc_clk_en_o) ? 5'h00 : gap_r + 5'h01;
    end
    sequence s_taken; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence s_rd(idx); wb_ack_o && !wb_we_i && wb_adr_i[13:2] == idx; endsequence
    property p_ack; s_taken |=> wb_ack_o; endproperty
    property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    property p_idle; !wb_ack_o |-> wb_dat_o == RST_DAT; endproperty
    property p_hi; wb_dat_o[DAT_W-1:REG_W] == '0; endproperty
    property p_rsv2; s_rd(IDX_CLK_REF) |-> wb_dat_o[5:4] == RSV_ZERO2; endproperty
    property p_rsv1; s_rd(IDX_UPPER_MASK) |-> wb_dat_o[7] == RSV_ZERO1; endproperty
    // channel is sampled at the taking edge, one before ack
    property p_chan;
        s_rd(IDX_UPPER_MASK) ##0 sweep_en_o
            |-> wb_dat_o == {{(DAT_W-CHAN_W){1'b0}}, $past(result_channel_i)};
    endproperty
    property p_ref;
        {ref_drive_bias_o, ref_use_ext_pin_o, ref_use_supply_o} ==
            {positive_reference_select_o == REF_BIAS, positive_reference_select_o == REF_EXT,
             positive_reference_select_o == REF_SUPPLY};
    endproperty
    // set lags the mode bits by one cycle, hence two samples
    property p_off; !sweep_en_o [*2] |-> sweep_set_o == '0; endproperty
    property p_diff;
        (sweep_en_o && differential_input_select_o) [*2] |-> sweep_set_o[SET_W-1:REG_W] == '0;
    endproperty
    property p_gap; gap_r <= 5'd15; endproperty
    a_ack: assert property (p_ack) else $error("no ack one cycle after request");
    a_pulse: assert property (p_pulse) else $error("ack longer than one cycle");
    a_idle: assert property (p_idle) else $error("read data outside ack");
    a_hi: assert property (p_hi) else $error("upper read data not zero");
    a_rsv2: assert property (p_rsv2) else $error("clock reserved bits not zero");
    a_rsv1: assert property (p_rsv1) else $error("mask bit seven not zero");
    a_chan: assert property (p_chan) else $error("sweep read not result channel");
    a_ref: assert property (p_ref) else $error("reference decode wrong");
    a_off: assert property (p_off) else $error("set not empty while idle");
    a_diff: assert property (p_diff) else $error("upper set in differential");
    a_gap: assert property (p_gap) else $error("converter clock too slow");
endmodule // acrss_checker

bind acrss_top acrss_checker acrss_checker_i (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .result_channel_i(result_channel_i),
    .adc_clk_en_o(adc_clk_en_o), .positive_reference_select_o(positive_reference_select_o),
    .ref_use_supply_o(ref_use_supply_o), .ref_use_ext_pin_o(ref_use_ext_pin_o),
    .ref_drive_bias_o(ref_drive_bias_o), .sweep_en_o(sweep_en_o),
    .differential_input_select_o(differential_input_select_o), .sweep_set_o(sweep_set_o));

// ==== bench/adc_clock_ref_scan_select_tb_top.sv ====
`timescale 1ns/1ns
// *******************************
// self-checking bench
// *******************************
module adc_clock_ref_scan_select_tb_top;
    import acrss_pkg::*;
    logic              clk_i = 1'b0;
    logic              rst_i = 1'b1;
    logic              wb_cyc_i = 1'b0;
    logic              wb_stb_i = 1'b0;
    logic              wb_we_i = 1'b0;
    logic [ADR_W-1:0]  wb_adr_i = '0;
    logic [SEL_W-1:0]  wb_sel_i = '0;
    logic [DAT_W-1:0]  wb_dat_i = '0;
    logic [CHAN_W-1:0] result_channel_i = '0;
    logic [DAT_W-1:0]  wb_dat_o, q;
    logic [SET_W-1:0]  sweep_set_o;
    logic [REF_W-1:0]  ref_sel;
    logic              wb_ack_o, adc_clk_en_o, sup, ext, bias, sweep_en_o, diff, sw, df;
    logic [7:0]        lo;
    logic [6:0]        up;
    logic [4:0]        chan;
    logic [3:0]        dv;
    int                num_errors = 0;
    int                cmp_count = 0;
    int                cyc_n = 0;
    int                tick_q[$];
    logic [IDX_W-1:0]  idxs[5] = '{IDX_SWEEP_CTRL, IDX_CLK_REF, IDX_UPPER_MASK,
                                   IDX_LOWER_SEL, 12'h000};

    acrss_top acrss_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .result_channel_i(result_channel_i), .adc_clk_en_o(adc_clk_en_o),
        .positive_reference_select_o(ref_sel), .ref_use_supply_o(sup),
        .ref_use_ext_pin_o(ext), .ref_drive_bias_o(bias), .sweep_en_o(sweep_en_o),
        .differential_input_select_o(diff), .sweep_set_o(sweep_set_o));

    // 100 ns system clock
    initial forever #50 clk_i = ~clk_i;

    // converter clock pulse times, in system cycles
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (adc_clk_en_o === 1'b1) tick_q.push_back(cyc_n);
    end

    task automatic check(input logic [DAT_W-1:0] seen, input logic [DAT_W-1:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask

    // one classic cycle; holds everything until ack is sampled
    task automatic bus(input logic we, input logic [IDX_W-1:0] idx, input logic [7:0] d,
                       input logic [SEL_W-1:0] sel, output logic [DAT_W-1:0] rd);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_sel_i <= sel;
        wb_dat_i <= {24'h0, d};
        n = 0;
        // no answer time assumed here; only the watchdog ends this wait
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1);
        // ack one cycle after the taking edge
        check(n, 2);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    function automatic logic [2:0] exp_ref(input logic [1:0] c);
        case (c)
            2'h0: return 3'b001;
            2'h1: return 3'b010;
            2'h3: return 3'b100;
            default: return 3'b000;
        endcase
    endfunction

    function automatic logic [SET_W-1:0] exp_set(logic s, logic f, logic [7:0] l,
                                                 logic [6:0] u);
        if (!s) return '0;
        return f ? {7'h00, l} : {u, l};
    endfunction

    // write lands just after a pulse, so the old count must run out first
    task automatic set_clk(input logic [1:0] rf, input logic [3:0] d, input int old);
        int n;
        @(posedge clk_i);
        tick_q = {};
        n = 0;
        while (tick_q.size() == 0 && n < 40) begin
            @(posedge clk_i);
            n++;
        end
        bus(1'b1, IDX_CLK_REF, {rf, 2'b00, d}, 4'h1, q);
        repeat (60) @(posedge clk_i);
        if (old >= 4) check(tick_q[1] - tick_q[0], old + 1);
        check(tick_q[$] - tick_q[$-1], d + 1);
        bus(1'b0, IDX_CLK_REF, 8'h00, 4'h1, q);
        check(q, {24'h0, rf, 2'b00, d});
        check({bias, ext, sup}, exp_ref(rf));
        check(ref_sel, rf);
    endtask

    task automatic conclude();
        if (num_errors == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // watchdog, far beyond the expected run
    initial begin
        #2000000;
        num_errors++;
        conclude();
    end

    initial begin
        void'($urandom(65));
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        check({bias, ext, sup}, 3'b001);
        // dropped writes: unmapped place and low byte not enabled
        bus(1'b1, 12'h000, 8'hff, 4'h1, q);
        bus(1'b1, IDX_LOWER_SEL, 8'h5a, 4'he, q);
        for (int i = 0; i < 5; i++) begin
            bus(1'b0, idxs[i], 8'h00, 4'h1, q);
            check(q, RST_DAT);
        end
        dv = 4'(4 + $urandom % 11);
        set_clk(2'h3, 4'hf, 0);
        set_clk(2'h2, 4'h7, 15);
        set_clk(2'h1, dv, 7);
        set_clk(2'h0, 4'h0, dv);
        // every sweep and input mode, random masks, all-ones corner first
        for (int i = 0; i < 8; i++) begin
            sw = i[1];
            df = i[0];
            lo = (i == 0) ? 8'hff : 8'($urandom);
            up = (i == 0) ? 7'h7f : 7'($urandom);
            chan = 5'($urandom);
            bus(1'b1, IDX_LOWER_SEL, lo, 4'h1, q);
            bus(1'b1, IDX_UPPER_MASK, {1'b0, up}, 4'h1, q);
            bus(1'b1, IDX_SWEEP_CTRL, {2'b00, sw, 1'b0, df, 3'b000}, 4'h1, q);
            repeat (2) @(posedge clk_i);
            check({sweep_en_o, diff}, {sw, df});
            check(sweep_set_o, exp_set(sw, df, lo, up));
            result_channel_i <= chan;
            bus(1'b0, IDX_UPPER_MASK, 8'h00, 4'h1, q);
            check(q, sw ? {27'h0, chan} : {25'h0, up});
            bus(1'b0, IDX_LOWER_SEL, 8'h00, 4'h1, q);
            check(q, {24'h0, lo});
        end
        conclude();
    end
endmodule // adc_clock_ref_scan_select_tb_top
